// ==== src/pcsia_core.sv ====
// pcsia_core: program counter sequencing, return stack control and the
// indirect pointer translation for an 8-bit core.
// assumes: the decoder gives one-cycle op strobes; memories answer
// combinationally to the address outputs of this block.
`timescale 1ns/1ps

// Behaviour
// - 15-bit pc, low byte register read/write
// - any reset clears the pc
// - high byte only from the latch
// - low-byte write loads high from latch
// - call: operand 10:0, latch bits 6:3
// - computed call: working low, latch high
// - branch by working: pc+1+w unsigned
// - relative branch: pc+1+signed operand
// - 16 x 15 stack outside memory spaces
// - calls/vector push, returns pop, latch untouched
// - option 0: push wraps circularly, pop at empty holds
// - 5-bit writable pointer, tos pair access
// - push increments first, return decrements after
// - option 1: overflow/underflow resets the device
// - self-pointing indirect: read zero, no write
// - pointer is 16 bits from two bytes
// - 0x000-0xFFF maps to absolute registers
// - 0x2000-0x29AF maps banked ram, else zero
// - linear region excludes common memory
// - flash region returns word low byte
// - indirect flash writes ignored
// - indirect flash read adds one cycle
module pcsia_core
   import pcsia_pkg::*;
(
   input wire logic clk_i, // core clock, 50 MHz
   input wire logic reset_i, // synchronous reset, any source
   input wire logic stack_error_reset_enable_i, // configuration option
   input wire pcsia_op_type op_i, // sequencing op, one cycle
   input wire logic [10:0] call_operand_i, // direct call target
   input wire logic [8:0] branch_operand_i, // signed relative offset
   input wire logic [7:0] working_i, // working register
   input wire logic pcl_write_i, // write to low-byte register
   input wire logic latch_write_i, // write to high latch
   input wire logic sp_write_i, // write to stack pointer
   input wire logic tos_low_write_i, // write to top entry low
   input wire logic tos_high_write_i, // write to top entry high
   input wire logic [7:0] wdata_i, // register write data
   input wire logic [7:0] ptr_low_i, // indirect pointer low byte
   input wire logic [7:0] ptr_high_i, // indirect pointer high byte
   input wire logic ind_read_i, // read of indirect data port
   input wire logic ind_write_i, // write of indirect data port
   input wire logic [7:0] ind_wdata_i, // data for indirect write
   input wire logic [7:0] data_rdata_i, // data memory read data
   input wire logic [13:0] flash_rdata_i, // program flash word
   output logic [14:0] pc_o, // program counter
   output logic [7:0] prog_counter_low_reg_o, // low byte register
   output logic [6:0] counter_high_latch_o, // high latch register
   output logic [4:0] return_stack_pointer_o, // stack pointer
   output logic [7:0] top_entry_low_o, // top entry low byte
   output logic [6:0] top_entry_high_o, // top entry high byte
   output logic stack_overflow_flag_o, // sticky overflow flag
   output logic stack_underflow_flag_o, // sticky underflow flag
   output logic stack_reset_o, // stack error reset request
   output logic [11:0] data_addr_o, // data memory address
   output logic data_read_o, // data memory read strobe
   output logic data_write_o, // data memory write strobe
   output logic [7:0] data_wdata_o, // data memory write data
   output logic [14:0] flash_addr_o, // flash address
   output logic flash_read_o, // flash read strobe
   output logic [7:0] ind_rdata_o, // indirect read result
   output logic ind_stall_o // extra cycle for flash read
);
   pcsia_stack_if st ();

   logic [14:0] pc;
   logic [6:0] latch;
   logic [14:0] next_pc;
   logic [14:0] pc_inc;
   logic ovf_flag;
   logic unf_flag;
   logic [15:0] ptr;
   logic [15:0] lin_off;
   logic [15:0] bank;
   logic [15:0] byte_sel;
   pcsia_region_type region;
   logic self_ptr;
   logic [15:0] lin_abs;

   pcsia_stack #(.DEPTH(STACK_DEPTH)) u_stack (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .st(st.stack)
   );

   assign pc_inc = pc + 15'h0001;

   // pc next value for each sequencing op
   always_comb begin
      next_pc = pc;
      case (op_i)
         PCSIA_OP_CALL: begin
            next_pc = {latch[6:3], call_operand_i};
         end
         PCSIA_OP_COMPUTED_CALL: begin
            next_pc = {latch, working_i};
         end
         PCSIA_OP_BRW: begin
            next_pc = pc_inc + {7'h00, working_i};
         end
         PCSIA_OP_BRA: begin
            next_pc = pc_inc + {{6{branch_operand_i[8]}}, branch_operand_i};
         end
         PCSIA_OP_RETURN: begin
            next_pc = st.tos;
         end
         PCSIA_OP_VECTOR: begin
            next_pc = PC_RESET;
         end
         PCSIA_OP_INCR: begin
            next_pc = pc_inc;
         end
         PCSIA_OP_NONE: begin
            next_pc = pc;
         end
         default: begin
            next_pc = pc;
         end
      endcase
      if (pcl_write_i) begin
         next_pc = {latch, wdata_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i || stack_reset_o) begin
         pc <= PC_RESET;
      end else begin
         pc <= next_pc;
      end
   end

   // pushes and pops never touch the latch
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         latch <= 7'h00;
      end else if (latch_write_i) begin
         latch <= wdata_i[6:0];
      end
   end

   assign st.push = (op_i == PCSIA_OP_CALL) || (op_i == PCSIA_OP_COMPUTED_CALL)
      || (op_i == PCSIA_OP_VECTOR);
   assign st.pop = (op_i == PCSIA_OP_RETURN);
   assign st.push_value = pc_inc;
   assign st.sp_write = sp_write_i;
   assign st.sp_wdata = wdata_i[4:0];
   assign st.tos_write_low = tos_low_write_i;
   assign st.tos_write_high = tos_high_write_i;
   assign st.tos_wdata = wdata_i;

   // flags are sticky; only a power-up style reset clears them
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ovf_flag <= 1'b0;
         unf_flag <= 1'b0;
      end else begin
         ovf_flag <= ovf_flag | st.overflow;
         unf_flag <= unf_flag | st.underflow;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         stack_reset_o <= 1'b0;
      end else begin
         stack_reset_o <= stack_error_reset_enable_i
            && (st.overflow || st.underflow);
      end
   end

   // indirect pointer decode
   assign ptr = {ptr_high_i, ptr_low_i};
   assign lin_off = ptr - LINEAR_BASE;
   assign bank = lin_off / BANK_GPR_SIZE;
   assign byte_sel = lin_off % BANK_GPR_SIZE;
   // common bytes sit past the 80-byte block, so they are never reached
   assign lin_abs = bank * BANK_STRIDE + BANK_GPR_BASE + byte_sel;

   always_comb begin
      if (ptr[FLASH_BIT]) begin
         region = PCSIA_REG_FLASH;
      end else if (ptr <= TRAD_LAST) begin
         region = PCSIA_REG_TRAD;
      end else if (ptr >= LINEAR_BASE && ptr <= LINEAR_LAST) begin
         region = PCSIA_REG_LINEAR;
      end else begin
         region = PCSIA_REG_NONE;
      end
   end

   assign self_ptr = (region == PCSIA_REG_TRAD) && (ptr[6:0] == IND_PORT0_ADDR
      || ptr[6:0] == IND_PORT1_ADDR);

   logic flash_wait;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         flash_wait <= 1'b0;
      end else begin
         flash_wait <= ind_read_i && region == PCSIA_REG_FLASH && !flash_wait;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         data_addr_o <= 12'h000;
         data_read_o <= 1'b0;
         data_write_o <= 1'b0;
         data_wdata_o <= 8'h00;
         flash_addr_o <= 15'h0000;
         flash_read_o <= 1'b0;
         ind_stall_o <= 1'b0;
      end else begin
         data_addr_o <= (region == PCSIA_REG_LINEAR) ? lin_abs[11:0] : ptr[11:0];
         data_read_o <= ind_read_i && !self_ptr
            && (region == PCSIA_REG_TRAD || region == PCSIA_REG_LINEAR);
         data_write_o <= ind_write_i && !self_ptr
            && (region == PCSIA_REG_TRAD || region == PCSIA_REG_LINEAR);
         data_wdata_o <= ind_wdata_i;
         flash_addr_o <= ptr[14:0];
         flash_read_o <= ind_read_i && region == PCSIA_REG_FLASH;
         ind_stall_o <= ind_read_i && region == PCSIA_REG_FLASH && !flash_wait;
      end
   end

   // result chosen against the registered strobes of the previous cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ind_rdata_o <= READ_ZERO;
      end else if (flash_read_o) begin
         ind_rdata_o <= flash_rdata_i[7:0];
      end else if (data_read_o) begin
         ind_rdata_o <= data_rdata_i;
      end else begin
         ind_rdata_o <= READ_ZERO;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pc_o <= PC_RESET;
         prog_counter_low_reg_o <= 8'h00;
         counter_high_latch_o <= 7'h00;
         return_stack_pointer_o <= SP_RESET;
         top_entry_low_o <= 8'h00;
         top_entry_high_o <= 7'h00;
         stack_overflow_flag_o <= 1'b0;
         stack_underflow_flag_o <= 1'b0;
      end else begin
         pc_o <= pc;
         prog_counter_low_reg_o <= pc[7:0];
         counter_high_latch_o <= latch;
         return_stack_pointer_o <= st.sp;
         top_entry_low_o <= st.tos[7:0];
         top_entry_high_o <= st.tos[14:8];
         stack_overflow_flag_o <= ovf_flag;
         stack_underflow_flag_o <= unf_flag;
      end
   end

   a_pcl_load: assert property (@(posedge clk_i) disable iff (reset_i)
      pcl_write_i && !stack_reset_o |=> pc == {$past(latch), $past(wdata_i)})
      else $error("low-byte write did not load pc");
   a_call_load: assert property (@(posedge clk_i) disable iff (reset_i)
      op_i == PCSIA_OP_CALL && !pcl_write_i && !stack_reset_o
      |=> pc == {$past(latch[6:3]), $past(call_operand_i)})
      else $error("call target wrong");
   a_computed_call_load: assert property (@(posedge clk_i) disable iff (reset_i)
      op_i == PCSIA_OP_COMPUTED_CALL && !pcl_write_i && !stack_reset_o
      |=> pc == {$past(latch), $past(working_i)})
      else $error("computed call target wrong");
   a_brw_load: assert property (@(posedge clk_i) disable iff (reset_i)
      op_i == PCSIA_OP_BRW && !pcl_write_i && !stack_reset_o
      |=> pc == 15'($past(pc) + 15'h0001 + {7'h00, $past(working_i)}))
      else $error("branch by working wrong");
   a_bra_load: assert property (@(posedge clk_i) disable iff (reset_i)
      op_i == PCSIA_OP_BRA && !pcl_write_i && !stack_reset_o
      |=> pc == 15'($past(pc) + 15'h0001 + {{6{$past(branch_operand_i[8])}},
      $past(branch_operand_i)})) else $error("relative branch wrong");
   a_reset_clear: assert property (@(posedge clk_i)
      reset_i |=> pc == PC_RESET ##1 pc_o == PC_RESET)
      else $error("reset did not clear pc");
   a_latch_kept: assert property (@(posedge clk_i) disable iff (reset_i)
      (st.push || st.pop) && !latch_write_i |=> $stable(latch))
      else $error("stack op changed latch");
   a_ovf_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
      st.overflow |=> ovf_flag ##1 stack_overflow_flag_o)
      else $error("overflow flag not set");
   a_unf_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
      st.underflow |=> unf_flag ##1 stack_underflow_flag_o)
      else $error("underflow flag not set");
   a_err_reset: assert property (@(posedge clk_i) disable iff (reset_i)
      stack_error_reset_enable_i && st.underflow |=> stack_reset_o ##1 pc == PC_RESET)
      else $error("stack error did not reset");
   a_self_ptr: assert property (@(posedge clk_i) disable iff (reset_i)
      ind_write_i && self_ptr |=> !data_write_o)
      else $error("self-pointing write not suppressed");
   a_flash_stall: assert property (@(posedge clk_i) disable iff (reset_i)
      ind_read_i && region == PCSIA_REG_FLASH && !flash_wait |=> ind_stall_o && flash_read_o)
      else $error("flash read without extra cycle");
endmodule : pcsia_core

// ==== src/pcsia_pkg.sv ====
// pcsia_pkg: constants and types for the program-counter, return stack and
// indirect addressing block.
// assumes: included before every other file of the block.
package pcsia_pkg;
   localparam int PC_WIDTH = 15;
   localparam int SP_WIDTH = 5;
   localparam int STACK_DEPTH = 16;
   localparam int LOW_WIDTH = 8;
   localparam int HIGH_WIDTH = 7;
   localparam int CALL_HIGH_BITS = 3;
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [4:0] SP_RESET = 5'h1F;
   localparam logic [4:0] SP_TOP = 5'h0F;
   localparam logic [15:0] TRAD_LAST = 16'h0FFF;
   localparam logic [15:0] LINEAR_BASE = 16'h2000;
   localparam logic [15:0] LINEAR_LAST = 16'h29AF;
   localparam logic [15:0] BANK_GPR_SIZE = 16'h0050;
   localparam logic [15:0] BANK_STRIDE = 16'h0080;
   localparam logic [15:0] BANK_GPR_BASE = 16'h0020;
   localparam int FLASH_BIT = 15;
   localparam logic [6:0] IND_PORT0_ADDR = 7'h00;
   localparam logic [6:0] IND_PORT1_ADDR = 7'h01;
   localparam logic [7:0] READ_ZERO = 8'h00;

   typedef enum logic [2:0] {
      PCSIA_OP_NONE,
      PCSIA_OP_CALL,
      PCSIA_OP_COMPUTED_CALL,
      PCSIA_OP_BRW,
      PCSIA_OP_BRA,
      PCSIA_OP_RETURN,
      PCSIA_OP_VECTOR,
      PCSIA_OP_INCR
   } pcsia_op_type;

   typedef enum logic [1:0] {
      PCSIA_REG_TRAD,
      PCSIA_REG_LINEAR,
      PCSIA_REG_FLASH,
      PCSIA_REG_NONE
   } pcsia_region_type;
endpackage : pcsia_pkg

// ==== src/pcsia_stack.sv ====
// pcsia_stack: 16 x 15 return-address stack with a 5-bit pointer.
// assumes: push and pop never come in the same cycle.
`timescale 1ns/1ps
module pcsia_stack
   import pcsia_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic clk_i, // core clock
   input wire logic reset_i, // synchronous reset
   pcsia_stack_if.stack st // stack port
);
   logic [14:0] entry [DEPTH];
   logic [4:0] sp;
   logic [4:0] next_sp;
   logic [3:0] slot;

   // push increments first, then stores; pop decrements after the pc took tos
   always_comb begin
      next_sp = sp;
      if (st.sp_write) begin
         next_sp = st.sp_wdata;
      end else if (st.push) begin
         next_sp = (sp == SP_TOP) ? 5'h00 : sp + 5'h01;
      end else if (st.pop) begin
         // popping the last entry empties the stack; an empty stack keeps its pointer
         next_sp = (sp == SP_RESET) ? SP_RESET : sp - 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sp <= SP_RESET;
      end else begin
         sp <= next_sp;
      end
   end

   assign slot = next_sp[3:0];

   always_ff @(posedge clk_i) begin
      if (st.push) begin
         entry[slot] <= st.push_value;
      end else if (st.tos_write_low) begin
         entry[sp[3:0]][7:0] <= st.tos_wdata;
      end else if (st.tos_write_high) begin
         entry[sp[3:0]][14:8] <= st.tos_wdata[6:0];
      end
   end

   assign st.sp = sp;
   assign st.tos = entry[sp[3:0]];
   assign st.overflow = st.push && (sp == SP_TOP);
   // a pop at pointer 0 returns from the first level; only a pop past it underflows
   assign st.underflow = st.pop && (sp == SP_RESET);

   a_push_wraps: assert property (@(posedge clk_i) disable iff (reset_i)
      st.push && !st.sp_write |=> sp == (($past(sp) == SP_TOP) ? 5'h00
      : $past(sp) + 5'h01)) else $error("push pointer step wrong");
endmodule : pcsia_stack

// ==== src/pcsia_stack_if.sv ====
// pcsia_stack_if: push/pop and pointer traffic between the sequencer and
// the return-address stack.
// assumes: one clock domain, driven by pcsia_core.
`timescale 1ns/1ps
interface pcsia_stack_if;
   logic push;
   logic pop;
   logic [14:0] push_value;
   logic sp_write;
   logic [4:0] sp_wdata;
   logic tos_write_low;
   logic tos_write_high;
   logic [7:0] tos_wdata;
   logic [4:0] sp;
   logic [14:0] tos;
   logic overflow;
   logic underflow;
   modport owner (output push, pop, push_value, sp_write, sp_wdata, tos_write_low,
      tos_write_high, tos_wdata, input sp, tos, overflow, underflow);
   modport stack (input push, pop, push_value, sp_write, sp_wdata, tos_write_low,
      tos_write_high, tos_wdata, output sp, tos, overflow, underflow);
endinterface : pcsia_stack_if

// ==== tb/pcsia_mem_model.sv ====
// pcsia_mem_model: data memory and program flash as seen through the indirect port.
// assumes: reads answer combinationally while the strobe is high; writes are watched
// by the bench at the core's own outputs.
`timescale 1ns/1ps
module pcsia_mem_model (
   input wire logic clk_i, // core clock
   input wire logic reset_i, // synchronous reset
   input wire logic [11:0] data_addr_i, // data memory address
   input wire logic data_read_i, // data memory read strobe
   input wire logic [14:0] flash_addr_i, // flash address
   input wire logic flash_read_i, // flash read strobe
   output logic [7:0] data_rdata_o, // data memory answer
   output logic [13:0] flash_rdata_o // flash word
);
   logic [7:0] last_data;
   logic [13:0] last_word;
   // outside a read the lines show the inverse of the last answer, so a late sample fails
   always_comb begin
      if (data_read_i) begin
         data_rdata_o = data_addr_i[7:0] ^ {data_addr_i[11:8], 4'h5};
      end else begin
         data_rdata_o = ~last_data;
      end
      if (flash_read_i) begin
         flash_rdata_o = flash_addr_i[13:0] ^ 14'h3f55; // upper bits must be dropped
      end else begin
         flash_rdata_o = ~last_word;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         last_data <= 8'h00;
         last_word <= 14'h0000;
      end else begin
         if (data_read_i) last_data <= data_rdata_o;
         if (flash_read_i) last_word <= flash_rdata_o;
      end
   end
endmodule : pcsia_mem_model

// ==== tb/test_pcsia_core.sv ====
// test_pcsia_core: self-checking bench for sequencing, return stack and indirect access.
// assumes: pcsia_mem_model answers for the memories; expectations come from a bench model.
`timescale 1ns/1ps
module test_pcsia_core
   import pcsia_pkg::*;
;
   typedef struct {int sel; logic [31:0] exp;} pcsia_note_type;
   logic clk_i = 1'b0, reset_i = 1'b1, ser = 1'b0, chk = 1'b0;
   pcsia_op_type op_i = PCSIA_OP_NONE;
   logic [10:0] call_operand_i = '0;
   logic [8:0] branch_operand_i = '0;
   logic [7:0] working_i = '0, wdata_i = '0, ind_wdata_i = '0, data_rdata_i;
   logic [4:0] strb = '0;
   logic [15:0] ptr = '0;
   logic ind_read_i = 1'b0, ind_write_i = 1'b0;
   logic [13:0] flash_rdata_i;
   logic [14:0] pc_o, flash_addr_o;
   logic [7:0] prog_counter_low_reg_o, top_entry_low_o, data_wdata_o, ind_rdata_o;
   logic [6:0] counter_high_latch_o, top_entry_high_o;
   logic [4:0] return_stack_pointer_o;
   logic stack_overflow_flag_o, stack_underflow_flag_o, stack_reset_o, data_read_o;
   logic data_write_o, flash_read_o, ind_stall_o;
   logic [11:0] data_addr_o;
   int num_errors = 0, comparisons = 0, n_rst = 0, n_wr = 0, n_stall = 0;
   logic [19:0] last_wr = '0;
   pcsia_note_type q[$];
   logic [31:0] seed = 32'h78eb;
   logic [14:0] m_pc, m_stk [16];
   logic [6:0] m_lat;
   logic [4:0] m_sp;
   logic m_ovf, m_unf;
   int m_rst = 0, m_wr = 0, m_stall = 0;
   logic [19:0] m_last = '0;

   pcsia_core pcsia_core_inst (.clk_i, .reset_i, .stack_error_reset_enable_i(ser), .op_i,
      .call_operand_i, .branch_operand_i, .working_i, .pcl_write_i(strb[4]),
      .latch_write_i(strb[3]), .sp_write_i(strb[2]), .tos_low_write_i(strb[1]),
      .tos_high_write_i(strb[0]), .wdata_i, .ptr_low_i(ptr[7:0]), .ptr_high_i(ptr[15:8]),
      .ind_read_i, .ind_write_i, .ind_wdata_i, .data_rdata_i, .flash_rdata_i, .pc_o,
      .prog_counter_low_reg_o, .counter_high_latch_o, .return_stack_pointer_o,
      .top_entry_low_o, .top_entry_high_o, .stack_overflow_flag_o, .stack_underflow_flag_o,
      .stack_reset_o, .data_addr_o, .data_read_o, .data_write_o, .data_wdata_o,
      .flash_addr_o, .flash_read_o, .ind_rdata_o, .ind_stall_o);
   pcsia_mem_model pcsia_mem_model_inst (.clk_i, .reset_i, .data_addr_i(data_addr_o),
      .data_read_i(data_read_o), .flash_addr_i(flash_addr_o), .flash_read_i(flash_read_o),
      .data_rdata_o(data_rdata_i), .flash_rdata_o(flash_rdata_i));

   always #10 clk_i = ~clk_i;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [31:0] obs(input int sel);
      case (sel)
         0: return {17'h0, pc_o};
         1: return {27'h0, return_stack_pointer_o};
         2: return {17'h0, top_entry_high_o, top_entry_low_o};
         3: return {24'h0, ind_rdata_o};
         4: return {30'h0, stack_overflow_flag_o, stack_underflow_flag_o};
         5: return {25'h0, counter_high_latch_o};
         6: return n_rst;
         7: return n_wr;
         8: return {12'h0, last_wr};
         9: return n_stall;
         default: return {24'h0, prog_counter_low_reg_o};
      endcase
   endfunction : obs
   // pointer to data address, bit 12 set when the pointer reaches no data location
   function automatic logic [12:0] xlat(input logic [15:0] p);
      logic [15:0] off;
      off = p - LINEAR_BASE;
      if (p <= TRAD_LAST) return {1'b0, p[11:0]};
      if (p >= LINEAR_BASE && p <= LINEAR_LAST) begin
         off = (off / BANK_GPR_SIZE) * BANK_STRIDE + BANK_GPR_BASE + off % BANK_GPR_SIZE;
         return {1'b0, off[11:0]};
      end
      return 13'h1000;
   endfunction : xlat
   function automatic logic [7:0] exp_rd(input logic [15:0] p);
      logic [12:0] a;
      a = xlat(p);
      if (p[15]) return p[7:0] ^ 8'h55;
      if (a[12] || (p <= TRAD_LAST && p[6:0] <= 7'h01)) return 8'h00;
      return a[7:0] ^ {a[11:8], 4'h5};
   endfunction : exp_rd

   always @(posedge clk_i) begin
      pcsia_note_type e;
      if (stack_reset_o === 1'b1) n_rst++;
      if (data_write_o === 1'b1) begin
         n_wr++;
         last_wr = {data_addr_o, data_wdata_o};
      end
      if (ind_stall_o === 1'b1) n_stall++;
      if (chk) begin
         while (q.size() > 0) begin
            e = q.pop_front();
            comparisons++;
            if (obs(e.sel) !== e.exp) begin
               num_errors++;
               $display("[FAIL] t=%0t item %0d got %h exp %h", $time, e.sel, obs(e.sel), e.exp);
            end
         end
      end
   end

   task automatic note(input int sel, input logic [31:0] exp);
      q.push_back('{sel, exp});
   endtask : note
   task automatic settle();
      op_i <= PCSIA_OP_NONE;
      strb <= 5'h00;
      @(posedge clk_i);
      chk <= 1'b1;
      @(posedge clk_i);
      chk <= 1'b0;
      @(posedge clk_i);
   endtask : settle
   task automatic check_core();
      note(0, m_pc);
      note(1, m_sp);
      note(4, {m_ovf, m_unf});
      note(5, m_lat);
      note(10, m_pc[7:0]);
      settle();
   endtask : check_core
   task automatic do_reset();
      reset_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      m_pc = PC_RESET;
      m_sp = SP_RESET;
      m_lat = 7'h00;
      m_ovf = 1'b0;
      m_unf = 1'b0;
   endtask : do_reset
   task automatic do_op(input pcsia_op_type op);
      logic [14:0] ret;
      int r0;
      ret = m_pc + 15'h0001;
      r0 = m_rst;
      op_i <= op;
      strb <= 5'h00;
      @(posedge clk_i);
      if (op inside {PCSIA_OP_CALL, PCSIA_OP_COMPUTED_CALL, PCSIA_OP_VECTOR}) begin
         if (m_sp == SP_TOP) m_ovf = 1'b1;
         if (m_sp == SP_TOP && ser) begin
            m_pc = PC_RESET;
            m_rst++;
         end else begin
            m_sp = (m_sp == SP_TOP) ? 5'h00 : m_sp + 5'h01;
            m_stk[m_sp[3:0]] = ret;
            if (op == PCSIA_OP_CALL) m_pc = {m_lat[6:3], call_operand_i};
            else if (op == PCSIA_OP_COMPUTED_CALL) m_pc = {m_lat, working_i};
            else m_pc = PC_RESET;
         end
      end else if (op == PCSIA_OP_RETURN) begin
         if (m_sp == SP_RESET) begin
            m_unf = 1'b1;
            if (ser) m_pc = PC_RESET;
            if (ser) m_rst++;
         end else begin
            m_pc = m_stk[m_sp[3:0]];
            m_sp = m_sp - 5'h01;
         end
      end else if (op == PCSIA_OP_BRW) m_pc = ret + {7'h00, working_i};
      else if (op == PCSIA_OP_BRA) m_pc = ret + {{6{branch_operand_i[8]}}, branch_operand_i};
      else if (op == PCSIA_OP_INCR) m_pc = ret;
      // the error reset clears the pc one cycle after the op itself
      if (m_rst != r0) op_i <= PCSIA_OP_NONE;
      if (m_rst != r0) @(posedge clk_i);
   endtask : do_op
   task automatic wr_reg(input int idx, input logic [7:0] d);
      strb <= 5'h01 << idx;
      wdata_i <= d;
      op_i <= PCSIA_OP_NONE;
      @(posedge clk_i);
      case (idx)
         4: m_pc = {m_lat, d};
         3: m_lat = d[6:0];
         2: m_sp = d[4:0];
         1: m_stk[m_sp[3:0]][7:0] = d;
         default: m_stk[m_sp[3:0]][14:8] = d[6:0];
      endcase
   endtask : wr_reg
   task automatic ind_rd(input logic [15:0] p);
      ptr <= p;
      ind_read_i <= 1'b1;
      @(posedge clk_i);
      // flash reads hold the strobe through the extra cycle
      if (p[15]) @(posedge clk_i);
      if (p[15]) m_stall++;
      // the read result stands one cycle for data and two for flash, so the check follows at once
      ind_read_i <= 1'b0;
      note(3, exp_rd(p));
      settle();
   endtask : ind_rd
   task automatic ind_wr(input logic [15:0] p, input logic [7:0] d);
      logic [12:0] a;
      a = xlat(p);
      ptr <= p;
      ind_write_i <= 1'b1;
      ind_wdata_i <= d;
      @(posedge clk_i);
      ind_write_i <= 1'b0;
      if (!p[15] && !a[12] && !(p <= TRAD_LAST && p[6:0] <= 7'h01)) m_wr++;
      if (!p[15] && !a[12] && !(p <= TRAD_LAST && p[6:0] <= 7'h01)) m_last = {a[11:0], d};
      repeat (2) @(posedge clk_i);
      note(7, m_wr);
      note(8, m_last);
      settle();
   endtask : ind_wr
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out

   initial begin
      #(200_000);
      num_errors++;
      close_out();
   end

   initial begin
      pcsia_op_type ops [9];
      logic [15:0] ptrs [12];
      ops = '{PCSIA_OP_CALL, PCSIA_OP_BRW, PCSIA_OP_COMPUTED_CALL, PCSIA_OP_BRA, PCSIA_OP_INCR,
         PCSIA_OP_VECTOR, PCSIA_OP_RETURN, PCSIA_OP_RETURN, PCSIA_OP_RETURN};
      ptrs = '{16'h0000, 16'h0001, 16'h0080, 16'h0ffe, 16'h1000, 16'h2000, 16'h204f,
         16'h2050, 16'h29af, 16'h29b0, 16'h8000, 16'hffff};
      do_reset();
      check_core();
      seed = lfsr(seed);
      wr_reg(3, seed[7:0]);
      wr_reg(4, seed[15:8]);
      check_core();
      $display("test counter load done");
      foreach (ops[i]) begin
         seed = lfsr(seed);
         call_operand_i <= seed[10:0];
         working_i <= seed[18:11];
         branch_operand_i <= seed[27:19];
         do_op(ops[i]);
         if (m_sp != SP_RESET) note(2, m_stk[m_sp[3:0]]);
         check_core();
      end
      do_op(PCSIA_OP_CALL);
      do_op(PCSIA_OP_RETURN);
      check_core();
      wr_reg(2, 8'h01);
      wr_reg(1, seed[7:0]);
      wr_reg(0, seed[15:8]);
      note(2, m_stk[1]);
      check_core();
      $display("test sequencing done");
      for (int s = 0; s < 2; s++) begin
         do_reset();
         ser <= s[0];
         for (int i = 0; i < 17; i++) begin
            seed = lfsr(seed);
            call_operand_i <= seed[10:0];
            do_op(PCSIA_OP_CALL);
            if (i == 15) note(4, 0);
            if (i == 15) settle();
         end
         if (!ser) note(2, m_stk[0]);
         note(0, m_pc);
         note(4, 2);
         note(6, m_rst);
         settle();
         do_reset();
         do_op(PCSIA_OP_RETURN);
         note(4, 1);
         note(6, m_rst);
         if (ser) note(0, PC_RESET);
         settle();
      end
      ser <= 1'b0;
      $display("test stack limits done");
      do_reset();
      foreach (ptrs[i]) ind_rd(ptrs[i]);
      seed = lfsr(seed);
      ind_rd({4'h0, seed[11:0]} | 16'h0004);
      ind_rd({1'b1, seed[26:12]});
      note(9, m_stall);
      ind_wr(16'h0123, seed[7:0]);
      ind_wr(16'h0001, seed[15:8]);
      ind_wr(16'h8010, seed[23:16]);
      ind_wr(16'h2050, seed[31:24]);
      $display("test indirect access done");
      close_out();
   end
endmodule : test_pcsia_core
